// >>> common/pll_cal_defines.svh
`ifndef PLL_CAL_DEFINES_SVH
`define PLL_CAL_DEFINES_SVH

// register indices (printed offsets are not multiples of four: byte addr = 4 * index)
`define IDX_TUNE_CTRL    6'h1b
`define IDX_PA_LEVEL     6'h1c
`define IDX_CAPS         6'h1d
`define IDX_PHASE_TRIM   6'h1e
`define IDX_GAIN_TRIM    6'h1f
// word index within a byte address
`define ADDR_IDX_HI      7
`define ADDR_IDX_LO      2
// nibble positions in the power and matching registers
`define NIB_UP_HI        7
`define NIB_UP_LO        4
`define NIB_DN_HI        3
`define NIB_DN_LO        0
// status register, read only
`define IDX_TUNE_STATUS  6'h3f

// reset values
`define RST_TUNE_CTRL    8'h05
`define RST_PA_LEVEL     8'h0f
`define RST_CAPS         8'h00
`define RST_PHASE_TRIM   8'h00
`define RST_GAIN_TRIM    8'h00

// field positions in the tuning control register
`define TC_START_BIT     7
`define TC_DUAL_BIT      6
`define TC_WAIT_HI       5
`define TC_WAIT_LO       4
`define TC_RSVD_BIT      3
`define TC_ITER_HI       2
`define TC_ITER_LO       0
`define TC_WRITE_MASK    8'hf7

// wait times in reference clock periods, codes 0 to 3
`define WAIT_CODE0       90000
`define WAIT_CODE1       110000
`define WAIT_CODE2       130000
`define WAIT_CODE3       200000

// axi responses
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// >>> common/pll_cal_pkg.sv
package pll_cal_pkg;

   // calibration sequencer states
   typedef enum logic [1:0] {
      cal_idle,
      cal_run,
      cal_store
   } cal_state_t;

endpackage

// >>> hw/cal_timer.sv
`timescale 1ns/1ns
`include "pll_cal_defines.svh"

// counts reference clock enables for the selected calibration wait
module cal_timer
   import pll_cal_pkg::*;
#(
   parameter int CNT_W = 18
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // control
   input  wire logic             start,
   input  wire logic             ref_tick,
   input  wire logic [1:0]       wait_code,
   input  wire logic [CNT_W-1:0] scale_div,
   // status
   output logic                  done
);

   typedef struct packed {
      logic [CNT_W-1:0] count;   // ticks left
      logic             busy;    // timer running
      logic             done;    // one-cycle end pulse
   } tmr_t;

   tmr_t cur;
   tmr_t next_cur;

   // map the wait code to a tick count; scale_div shortens it for simulation
   function automatic logic [CNT_W-1:0] wait_len(input logic [1:0] code,
                                                  input logic [CNT_W-1:0] div);
      logic [CNT_W-1:0] base;
      base = '0;
      unique case (code)
         2'h0: base = CNT_W'(`WAIT_CODE0);
         2'h1: base = CNT_W'(`WAIT_CODE1);
         2'h2: base = CNT_W'(`WAIT_CODE2);
         2'h3: base = CNT_W'(`WAIT_CODE3);
      endcase
      wait_len = (div > CNT_W'(1)) ? base / div : base;
   endfunction

   // next state
   always_comb begin
      next_cur      = cur;
      next_cur.done = 1'b0;
      if (start) begin
         next_cur.count = wait_len(wait_code, scale_div);
         next_cur.busy  = 1'b1;
      end else if (cur.busy && ref_tick) begin
         if (cur.count <= CNT_W'(1)) begin
            next_cur.busy  = 1'b0;
            next_cur.count = '0;
            next_cur.done  = 1'b1;
         end else begin
            next_cur.count = cur.count - CNT_W'(1);
         end
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign done = cur.done;

endmodule // cal_timer

// >>> hw/pll_cal_pa_trim_regs.sv
// Contract
// - rising start bit begins a calibration
// - dual bit stores to both sets
// - wait code held before the start write picks reference period count
// - iteration code plus one is dac start
// - upper power nibble drives high array
// - lower power nibble drives low array
// - upper match nibble selects rx caps
// - lower match nibble selects tx caps
// - phase trim is signed lo adjustment
// - gain trim is signed mixer adjustment
`timescale 1ns/1ns
`include "pll_cal_defines.svh"

module pll_cal_pa_trim_regs
   import pll_cal_pkg::*;
#(
   parameter int          REF_DIV   = 1,  // clk cycles per reference period
   parameter int          TIMER_W   = 18,
   parameter logic [17:0] WAIT_SCALE = 18'h0_0001 // divides wait counts in simulation
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   // axi4-lite write address
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // axi4-lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // axi4-lite read data
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // link to the main control register
   input  wire logic              freq_set_sel,
   // calibration results towards the synthesizer
   input  wire logic [3:0]        cal_result,
   output logic                   cal_active,
   output logic                   store_set_a,
   output logic                   store_set_b,
   output logic [3:0]             tune_dac_start_code,
   // analog trims
   output logic [3:0]             high_array_level,
   output logic [3:0]             low_array_level,
   output logic [3:0]             rx_match_code,
   output logic [3:0]             tx_match_code,
   output logic signed [7:0]      lo_phase_adjust,
   output logic signed [7:0]      mixer_gain_adjust
);

   // register state of the block apart from the select synchroniser and the timer
   typedef struct packed {
      logic [7:0]      tune_ctrl;     // pll_tuning_control
      logic [7:0]      pa_level;      // amplifier_power_level
      logic [7:0]      caps;          // antenna_tuning_caps
      logic [7:0]      phase_trim;    // lo_iq_phase_trim
      logic [7:0]      gain_trim;     // mixer_iq_gain_trim
      logic            aw_held;       // write address taken, awaiting data
      logic [5:0]      aw_idx;        // held write index
      logic            w_held;        // write data taken, awaiting address
      logic [31:0]     w_data;        // held write data
      logic [3:0]      w_strb;        // held write strobes
      logic            bvalid;
      logic [1:0]      bresp;
      logic            rvalid;
      logic [31:0]     rdata;
      logic [1:0]      rresp;
      cal_state_t      cal_state;     // calibration sequencer
      logic            dual_latched;  // dual-store captured at start
      logic            sel_latched;   // set select captured at start
      logic            store_a;       // result strobe to set a
      logic            store_b;       // result strobe to set b
      logic [3:0]      result;        // last stored result
      logic            done_seen;     // a calibration has finished
      logic [15:0]     div_cnt;       // reference period divider
      logic            ref_tick;      // one pulse per reference period
   } regs_t;

   regs_t cur;
   regs_t next_cur;

   // synchroniser for the frequency-set select; it comes from another block clock tree
   logic [2:0] sel_sync;
   logic       sel_stable;

   // timer interface
   logic       timer_start;
   logic       timer_done;

   // word index from a byte address; low two bits are ignored
   function automatic logic [5:0] word_idx(input logic [7:0] addr);
      word_idx = addr[`ADDR_IDX_HI:`ADDR_IDX_LO];
   endfunction

   // merge strobed bytes into an 8-bit register held in lane 0
   function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
      merge8 = strb[0] ? d[7:0] : old;
   endfunction

   // does an index name a writable register
   function automatic logic is_rw(input logic [5:0] idx);
      is_rw = (idx == `IDX_TUNE_CTRL) || (idx == `IDX_PA_LEVEL) || (idx == `IDX_CAPS) ||
              (idx == `IDX_PHASE_TRIM) || (idx == `IDX_GAIN_TRIM);
   endfunction

   // three-stage pin sampler; only stages two and three are looked at
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sel_sync   <= 3'h0;
         sel_stable <= 1'b0;
      end else begin
         sel_sync <= {sel_sync[1:0], freq_set_sel};
         if (sel_sync[1] == sel_sync[2]) begin
            sel_stable <= sel_sync[2];
         end
      end
   end

   // next state of registers, bus slave and calibration sequencer
   always_comb begin
      logic        do_write;
      logic [5:0]  wr_idx;
      logic [31:0] wr_data;
      logic [3:0]  wr_strb;
      logic [7:0]  new_ctrl;
      logic [5:0]  rd_idx;
      do_write  = 1'b0;
      wr_idx    = '0;
      wr_data   = '0;
      wr_strb   = '0;
      new_ctrl  = '0;
      rd_idx    = '0;
      next_cur  = cur;
      timer_start = 1'b0;
      next_cur.store_a  = 1'b0;
      next_cur.store_b  = 1'b0;
      next_cur.ref_tick = 1'b0;

      // reference period enable; the wait is counted in these ticks
      if (cur.div_cnt >= 16'(REF_DIV - 1)) begin
         next_cur.div_cnt  = '0;
         next_cur.ref_tick = 1'b1;
      end else begin
         next_cur.div_cnt = cur.div_cnt + 16'h0001;
      end

      // address and data may arrive in either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_cur.aw_held = 1'b1;
         next_cur.aw_idx  = word_idx(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_cur.w_held = 1'b1;
         next_cur.w_data = s_axi_wdata;
         next_cur.w_strb = s_axi_wstrb;
      end

      // perform the write once both halves are present and no response is pending
      if (next_cur.aw_held && next_cur.w_held && !cur.bvalid) begin
         do_write         = 1'b1;
         wr_idx           = next_cur.aw_idx;
         wr_data          = next_cur.w_data;
         wr_strb          = next_cur.w_strb;
         next_cur.aw_held = 1'b0;
         next_cur.w_held  = 1'b0;
         next_cur.bvalid  = 1'b1;
         next_cur.bresp   = is_rw(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (cur.bvalid && s_axi_bready) begin
         next_cur.bvalid = 1'b0;
      end

      if (do_write) begin
         unique case (wr_idx)
            `IDX_TUNE_CTRL: begin
               // reserved bit is forced to zero whatever the host writes
               new_ctrl = merge8(cur.tune_ctrl, wr_data, wr_strb) & `TC_WRITE_MASK;
               next_cur.tune_ctrl = new_ctrl;
               // only a 0 to 1 edge of the start bit launches a run
               if (new_ctrl[`TC_START_BIT] && !cur.tune_ctrl[`TC_START_BIT]) begin
                  timer_start           = 1'b1;
                  next_cur.cal_state    = cal_run;
                  next_cur.dual_latched = new_ctrl[`TC_DUAL_BIT];
                  next_cur.sel_latched  = sel_stable;
                  next_cur.done_seen    = 1'b0;
               end
            end
            `IDX_PA_LEVEL:   next_cur.pa_level   = merge8(cur.pa_level, wr_data, wr_strb);
            `IDX_CAPS:       next_cur.caps       = merge8(cur.caps, wr_data, wr_strb);
            `IDX_PHASE_TRIM: next_cur.phase_trim = merge8(cur.phase_trim, wr_data, wr_strb);
            `IDX_GAIN_TRIM:  next_cur.gain_trim  = merge8(cur.gain_trim, wr_data, wr_strb);
            default: begin
               // unmapped: nothing stored, error response already set
            end
         endcase
      end

      // calibration sequencer
      unique case (cur.cal_state)
         cal_idle: begin
         end
         cal_run: begin
            // a restart written in this cycle keeps the run going
            if (timer_done && !timer_start) begin
               next_cur.cal_state = cal_store;
            end
         end
         cal_store: begin
            // dual-store writes both sets, otherwise the selected one only
            next_cur.store_a   = cur.dual_latched || !cur.sel_latched;
            next_cur.store_b   = cur.dual_latched || cur.sel_latched;
            next_cur.result    = cal_result;
            next_cur.done_seen = 1'b1;
            // a restart written in this very cycle wins over the return to idle
            if (!timer_start) begin
               next_cur.cal_state = cal_idle;
            end
         end
      endcase

      // read channel: one read at a time, answered the cycle after the address
      if (s_axi_arvalid && s_axi_arready) begin
         rd_idx          = word_idx(s_axi_araddr);
         next_cur.rvalid = 1'b1;
         next_cur.rresp  = `RESP_OKAY;
         next_cur.rdata  = '0;
         unique case (rd_idx)
            `IDX_TUNE_CTRL:   next_cur.rdata = {24'h00_0000, cur.tune_ctrl};
            `IDX_PA_LEVEL:    next_cur.rdata = {24'h00_0000, cur.pa_level};
            `IDX_CAPS:        next_cur.rdata = {24'h00_0000, cur.caps};
            `IDX_PHASE_TRIM:  next_cur.rdata = {24'h00_0000, cur.phase_trim};
            `IDX_GAIN_TRIM:   next_cur.rdata = {24'h00_0000, cur.gain_trim};
            `IDX_TUNE_STATUS: next_cur.rdata = {24'h00_0000, cur.result, 1'b0,
                                                sel_stable, cur.done_seen,
                                                cur.cal_state != cal_idle};
            default:          next_cur.rresp = `RESP_SLVERR;
         endcase
      end else if (cur.rvalid && s_axi_rready) begin
         next_cur.rvalid = 1'b0;
      end
   end

   // register the whole state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cur            <= '0;
         cur.tune_ctrl  <= `RST_TUNE_CTRL;
         cur.pa_level   <= `RST_PA_LEVEL;
         cur.caps       <= `RST_CAPS;
         cur.phase_trim <= `RST_PHASE_TRIM;
         cur.gain_trim  <= `RST_GAIN_TRIM;
         cur.cal_state  <= cal_idle;
      end else begin
         cur <= next_cur;
      end
   end

   // wait-time counter in reference periods
   cal_timer #(
      .CNT_W     (TIMER_W)
   ) u_timer (
      .clk       (clk),
      .rst_b     (rst_b),
      .start     (timer_start),
      .ref_tick  (cur.ref_tick),
      .wait_code (cur.tune_ctrl[`TC_WAIT_HI:`TC_WAIT_LO]),
      .scale_div (TIMER_W'(WAIT_SCALE)),
      .done      (timer_done)
   );

   // bus handshakes; held halves stall their own channel
   assign s_axi_awready = !cur.aw_held && !cur.bvalid;
   assign s_axi_wready  = !cur.w_held && !cur.bvalid;
   assign s_axi_arready = !cur.rvalid;
   assign s_axi_bvalid  = cur.bvalid;
   assign s_axi_bresp   = cur.bresp;
   assign s_axi_rvalid  = cur.rvalid;
   assign s_axi_rdata   = cur.rdata;
   assign s_axi_rresp   = cur.rresp;

   // calibration outputs
   assign cal_active  = cur.cal_state != cal_idle;
   assign store_set_a = cur.store_a;
   assign store_set_b = cur.store_b;
   // dac start is the code plus one, so 1 to 8 needs four bits
   assign tune_dac_start_code = {1'b0, cur.tune_ctrl[`TC_ITER_HI:`TC_ITER_LO]} + 4'h1;

   // analog trims straight from the registers
   assign high_array_level  = cur.pa_level[`NIB_UP_HI:`NIB_UP_LO];
   assign low_array_level   = cur.pa_level[`NIB_DN_HI:`NIB_DN_LO];
   assign rx_match_code     = cur.caps[`NIB_UP_HI:`NIB_UP_LO];
   assign tx_match_code     = cur.caps[`NIB_DN_HI:`NIB_DN_LO];
   assign lo_phase_adjust   = cur.phase_trim;
   assign mixer_gain_adjust = cur.gain_trim;

endmodule // pll_cal_pa_trim_regs

// >>> sim/host_model.sv
`timescale 1ns/1ns

// bus master standing in for the host controller; waits a random gap before each request
module host_model (
   // clock
   input wire logic        clk,
   // write side
   output logic [7:0]      s_axi_awaddr,
   output logic            s_axi_awvalid,
   input wire logic        s_axi_awready,
   output logic [31:0]     s_axi_wdata,
   output logic [3:0]      s_axi_wstrb,
   output logic            s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   output logic            s_axi_bready,
   // read side
   output logic [7:0]      s_axi_araddr,
   output logic            s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   output logic            s_axi_rready
);
   // idle values at time zero
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready, s_axi_wstrb} = '0;
   end

   // one write; released lines show the inverse so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      repeat ($urandom_range(2)) @(posedge clk);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask

   // one read; data is judged by the bench monitor
   task automatic rd(input logic [7:0] a);
      repeat ($urandom_range(2)) @(posedge clk);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
endmodule // host_model

// >>> sim/pll_cal_pa_trim_regs_bench.sv
`timescale 1ns/1ns
`include "pll_cal_defines.svh"

module pll_cal_pa_trim_regs_bench
   import pll_cal_pkg::*;
;
   // byte addresses and reset values, control first
   localparam logic [7:0] ADDR [5] = '{{`IDX_TUNE_CTRL, 2'b00}, {`IDX_PA_LEVEL, 2'b00},
      {`IDX_CAPS, 2'b00}, {`IDX_PHASE_TRIM, 2'b00}, {`IDX_GAIN_TRIM, 2'b00}};
   localparam logic [7:0] RST [5] = '{`RST_TUNE_CTRL, `RST_PA_LEVEL, `RST_CAPS,
      `RST_PHASE_TRIM, `RST_GAIN_TRIM};
   localparam int WAITS [4] = '{`WAIT_CODE0, `WAIT_CODE1, `WAIT_CODE2, `WAIT_CODE3};
   localparam int SCALE = 1000; // shortens each wait to 90 to 200 cycles

   logic              clk, rst_b, freq_set_sel;
   logic [7:0]        s_axi_awaddr, s_axi_araddr;
   logic [31:0]       s_axi_wdata, s_axi_rdata;
   logic [3:0]        s_axi_wstrb, cal_result, tune_dac_start_code;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic              s_axi_rvalid, s_axi_rready, cal_active, store_set_a, store_set_b;
   logic [3:0]        high_array_level, low_array_level, rx_match_code, tx_match_code;
   logic signed [7:0] lo_phase_adjust, mixer_gain_adjust;
   logic [33:0]       qr [$];   // expected {rresp, rdata}
   logic [1:0]        qb [$];   // expected bresp
   int                mismatches, n_tests, n;
   logic [7:0]        v, got;

   pll_cal_pa_trim_regs #(.WAIT_SCALE(18'(SCALE))) dut_u (.*);
   host_model host_u (.*);

   // 50 ns clock
   initial clk = 1'b0;
   always #25 clk = ~clk;

   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // drivers note the expectation before the request goes out
   task automatic wchk(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r,
                       input logic [3:0] s = 4'hf);
      qb.push_back(r);
      host_u.wr(a, {24'h0, d}, s);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      qr.push_back({`RESP_OKAY, 24'h0, e});
      host_u.rd(a);
   endtask

   // monitor takes the oldest note at each response handshake
   always @(posedge clk) begin
      if (s_axi_bvalid && s_axi_bready) chk(34'(s_axi_bresp), 34'(qb.pop_front()));
      if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, qr.pop_front());
   end

   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // watchdog well beyond the few thousand cycles the tests need
   initial begin
      #(50 * 40000);
      mismatches++;
      results();
   end

   initial begin
      {rst_b, freq_set_sel, cal_result} = '0;
      void'($urandom(37345));
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      // reset values on the bus and at the trim ports
      for (int i = 0; i < 5; i++) rchk(ADDR[i], RST[i]);
      chk(34'({high_array_level, low_array_level, tune_dac_start_code}), 34'h0f6);
      $display("test reset values done");
      // random, then both signed extremes, into every trim register
      for (int p = 0; p < 3; p++) begin
         for (int i = 1; i < 5; i++) begin
            v = (p == 0) ? 8'($urandom) : (p == 1) ? 8'h80 : 8'h7f;
            wchk(ADDR[i], v, `RESP_OKAY);
            got = (i == 1) ? {high_array_level, low_array_level} :
                  (i == 2) ? {rx_match_code, tx_match_code} :
                  (i == 3) ? lo_phase_adjust : mixer_gain_adjust;
            chk(34'(got), 34'(v));
            rchk(ADDR[i], v);
         end
      end
      wchk(8'h40, 8'h5a, `RESP_SLVERR);
      // lane zero strobe off: the register must keep its value
      wchk(ADDR[1], 8'h00, `RESP_OKAY, 4'he);
      rchk(ADDR[1], 8'h7f);
      // power set through the low nibble only, high array off
      wchk(ADDR[1], 8'h0a, `RESP_OKAY);
      chk(34'({high_array_level, low_array_level}), 34'h0a);
      $display("test trims done");
      // every iteration code, reserved bit written one and read back zero
      for (int c = 0; c < 8; c++) begin
         v = {1'b0, 3'($urandom), 1'b1, 3'(c)};
         wchk(ADDR[0], v, `RESP_OKAY);
         chk(34'(tune_dac_start_code), 34'(c + 1));
         rchk(ADDR[0], v & `TC_WRITE_MASK);
      end
      $display("test iteration codes done");
      // every wait code, single and dual store, random set select
      for (int k = 0; k < 8; k++) begin
         freq_set_sel <= 1'($urandom);
         cal_result <= 4'($urandom);
         repeat (5) @(posedge clk);
         v = {1'b0, 1'(k >> 2), 2'(k), 4'h4};
         wchk(ADDR[0], v, `RESP_OKAY);
         wchk(ADDR[0], v | 8'h80, `RESP_OKAY);
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (!(store_set_a || store_set_b) && n < 1000);
         chk(34'({store_set_a, store_set_b}),
             34'({v[6] | ~freq_set_sel, v[6] | freq_set_sel}));
         chk(34'(n >= WAITS[k % 4] / SCALE - 3 &&
                 n <= WAITS[k % 4] / SCALE + 3), 34'h1);
         rchk(ADDR[0], v | 8'h80);
         // status: result captured, synced set select, done seen, not busy
         rchk({`IDX_TUNE_STATUS, 2'b00}, {cal_result, 1'b0, freq_set_sel, 2'b10});
      end
      $display("test calibration done");
      repeat (5) @(posedge clk);
      results();
   end
endmodule // pll_cal_pa_trim_regs_bench

// >>> sim/pll_cal_pa_trim_regs_sva.sv
`timescale 1ns/1ns
`include "pll_cal_defines.svh"

// port checker for the register slice; ports not watched are left out of the list, except s_axi_awready and s_axi_wready
module pll_cal_pa_trim_regs_sva
   import pll_cal_pkg::*;
(
   // clock and reset
   input wire logic       clk,
   input wire logic       rst_b,
   // bus handshakes
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready,
   // calibration and trims
   input wire logic       cal_active,
   input wire logic       store_set_a,
   input wire logic       store_set_b,
   input wire logic [3:0] tune_dac_start_code,
   input wire logic [3:0] high_array_level,
   input wire logic signed [7:0] lo_phase_adjust
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // responses stand until taken
   a_b_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("bresp dropped early");
   a_r_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("rdata dropped early");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_ar_refused: assert property (
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   // dac start code is field plus one, never zero
   a_dac_range: assert property (
      tune_dac_start_code inside {[1:8]})
      else $error("dac code out of range");
   // a calibration only begins from a completed write
   a_cal_start: assert property (
      $rose(cal_active) |-> $rose(s_axi_bvalid))
      else $error("calibration began unasked");
   a_store_end: assert property (
      $fell(cal_active) |-> store_set_a || store_set_b)
      else $error("no store at end");
   a_store_pulse: assert property (
      store_set_a || store_set_b |=> !store_set_a && !store_set_b)
      else $error("store not a pulse");
   // trims move only when a write lands
   a_level_write: assert property (
      $changed(high_array_level) |-> $rose(s_axi_bvalid))
      else $error("level moved unasked");
   a_trim_write: assert property (
      $changed(lo_phase_adjust) |-> $rose(s_axi_bvalid))
      else $error("phase moved unasked");

   c_cal_done: cover property ($fell(cal_active));
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
endmodule // pll_cal_pa_trim_regs_sva

bind pll_cal_pa_trim_regs pll_cal_pa_trim_regs_sva chk_u (.*);
